// >>> uhp_pkg.sv
package uhp_pkg;

  // ------------------------------------------------------------
  // clock and bit-rate figures
  // ------------------------------------------------------------
  localparam int CLK_HZ = 250000000; // core clock rate
  localparam int BAUD_MIN = 1200; // slowest rate served
  localparam int BAUD_MAX = 4000000; // fastest rate served
  localparam int BAUD_RESET = 115200; // rate loaded in reset; cfg_in replaces it on the first clock after reset
  localparam int DIV_W = 18; // width of a clocks-per-bit divisor
  // divisors round down, so 4M comes out at 62 clocks, about 0.8 percent fast
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / BAUD_RESET);
  localparam logic [DIV_W-1:0] DIV_ONE = 18'h00001; // step of the bit counter

  // ------------------------------------------------------------
  // character format and pin slots
  // ------------------------------------------------------------
  localparam logic [2:0] LAST_DATA_BIT = 3'h7; // eight data bits, index 0..7
  localparam int PIN_TX = 0; // transmit line slot
  localparam int PIN_RX = 1; // receive line slot
  localparam int PIN_RTS = 2; // request-to-send, or i2c clock
  localparam int PIN_CTS = 3; // clear-to-send, or i2c data
  localparam int PIN_N = 4; // shared pins

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    UHP_PULL_WEAK_UP,
    UHP_PULL_STRONG_UP,
    UHP_PULL_WEAK_DOWN,
    UHP_PULL_STRONG_DOWN
  } uhp_pull_t;

  typedef enum logic [1:0] {
    UHP_PAR_NONE,
    UHP_PAR_ODD,
    UHP_PAR_EVEN
  } uhp_par_t;

  typedef enum {
    UHP_ST_IDLE,
    UHP_ST_START,
    UHP_ST_DATA,
    UHP_ST_PARITY,
    UHP_ST_STOP
  } uhp_st_t;

  // firmware-written port configuration
  typedef struct packed {
    logic [DIV_W-1:0] divisor; // core clocks per bit
    uhp_par_t parity; // none, odd or even
    logic two_stop; // 1: two stop bits
    logic flow_en; // hardware flow control on
    logic i2c_sel; // handshake pins carry i2c
    logic [PIN_N-1:0] gpl_sel; // 1: pin is a general line
  } uhp_cfg_t;

  // software control of one general programmable line
  typedef struct packed {
    logic drive; // level driven
    logic oe; // 1: line driven
    uhp_pull_t pull; // pull strength and sense
  } uhp_gpl_t;

  // pull codes held while reset is high
  localparam uhp_pull_t PULL_RESET_UART = UHP_PULL_STRONG_UP;
  localparam uhp_pull_t PULL_RESET_HS = UHP_PULL_WEAK_UP;

endpackage

// >>> uhp_pad_cell.sv
`timescale 1ns/10ps
module uhp_pad_cell
  import uhp_pkg::*;
#(
  parameter uhp_pull_t RESET_PULL = UHP_PULL_WEAK_UP
) (
  input wire logic clk_in, // core clock
  input wire logic reset_in, // synchronous, active high
  input wire logic serial_sel_in, // 1: serial function owns the pin
  input wire logic fn_drive_in, // serial function level
  input wire logic fn_oe_in, // serial function enable
  input wire uhp_gpl_t gpl_in, // software line control
  input wire logic pin_in, // pad level
  output logic pin_out, // pad drive level
  output logic pin_oe_out, // high while driving
  output uhp_pull_t pull_out, // pull select to the pad
  output logic sync_out // pad level after two flops
);

  // ------------------------------------------------------------
  // pad state
  // ------------------------------------------------------------
  logic drive_q, drive_d; // registered drive level
  logic oe_q, oe_d; // registered enable
  uhp_pull_t pull_q, pull_d; // registered pull code
  logic meta_q, meta_d; // first synchroniser flop, read only by sync_q
  logic sync_q, sync_d; // second synchroniser flop

  // choose serial or software control of the pin
  always_comb begin
    drive_d = serial_sel_in ? fn_drive_in : gpl_in.drive;
    oe_d = serial_sel_in ? fn_oe_in : gpl_in.oe;
    pull_d = gpl_in.pull;
    meta_d = pin_in;
    sync_d = meta_q;
  end

  // pad stays undriven with its reset pull until reset drops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      drive_q <= 1'b1;
      oe_q <= 1'b0;
      pull_q <= RESET_PULL;
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      drive_q <= drive_d;
      oe_q <= oe_d;
      pull_q <= pull_d;
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_out = drive_q;
  assign pin_oe_out = oe_q;
  assign pull_out = pull_q;
  assign sync_out = sync_q;

endmodule

// >>> uhp_host_port.sv
`timescale 1ns/10ps
// How it works
// - handshake lines are active low
// - handshake pins become general lines without flow or i2c
// - divisor clamped to 1200 baud .. 4M baud
// - parity none, odd or even
// - eight data bits, one or two stops
// - format comes from firmware configuration port
// - i2c takes handshake pins, excluding flow control
// - four serial pins selectable as general lines
// - each line has a selectable pull
// - async framing on separate transmit, receive lines
module uhp_host_port
  import uhp_pkg::*;
(
  input wire logic clk_in, // core clock, 250 MHz
  input wire logic reset_in, // synchronous, active high
  input wire uhp_cfg_t cfg_in, // firmware configuration
  input wire uhp_gpl_t [PIN_N-1:0] gpl_in, // software line control
  input wire logic tx_valid_in, // character offered
  input wire logic [7:0] tx_data_in, // character to send
  output logic tx_ready_out, // transmitter takes the character
  input wire logic rx_ready_in, // receive side can take characters
  output logic rx_valid_out, // one-cycle pulse, character received
  output logic [7:0] rx_data_out, // received character
  output logic rx_parity_err_out, // parity mismatch on that character
  output logic rx_frame_err_out, // low stop bit on that character
  input wire logic i2c_scl_low_in, // i2c master pulls clock low
  input wire logic i2c_sda_low_in, // i2c master pulls data low
  output logic i2c_scl_out, // clock pin level
  output logic i2c_sda_out, // data pin level
  output logic [PIN_N-1:0] gpl_level_out, // pin levels as sampled
  input wire logic [PIN_N-1:0] pin_in, // pad levels
  output logic [PIN_N-1:0] pin_out, // pad drive levels
  output logic [PIN_N-1:0] pin_oe_out, // pad enables, high drives
  output uhp_pull_t [PIN_N-1:0] pull_out // pad pull codes
);

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  uhp_cfg_t cfg_q, cfg_d; // active format
  uhp_st_t tx_st_q, tx_st_d; // transmitter state
  uhp_st_t rx_st_q, rx_st_d; // receiver state
  logic [DIV_W-1:0] div_eff; // clamped clocks per bit
  logic flow_act; // flow control really in use
  logic [PIN_N-1:0] ser_sel; // pin owned by the serial function
  logic [PIN_N-1:0] fn_drive; // serial function levels
  logic [PIN_N-1:0] fn_oe; // serial function enables
  logic [PIN_N-1:0] pin_sync; // synchronised pad levels
  logic tx_line_q, tx_line_d; // transmit line level
  logic rts_n; // low: host may send

  // new format only between characters, so no frame is split
  always_comb begin
    cfg_d = cfg_q;
    if ((tx_st_q == UHP_ST_IDLE) && (rx_st_q == UHP_ST_IDLE)) begin
      cfg_d = cfg_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin // reset held long by the host
      cfg_q <= '{divisor: DIV_RESET, parity: UHP_PAR_NONE, default: '0};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // out-of-range divisors are pulled back to the served span
  always_comb begin
    if (cfg_q.divisor < DIV_MIN) begin
      div_eff = DIV_MIN;
    end else if (cfg_q.divisor > DIV_MAX) begin
      div_eff = DIV_MAX;
    end else begin
      div_eff = cfg_q.divisor;
    end
  end

  // ------------------------------------------------------------
  // pin sharing
  // ------------------------------------------------------------
  // i2c wins over flow control, they cannot share the pins
  assign flow_act = cfg_q.flow_en & ~cfg_q.i2c_sel;
  assign rts_n = ~rx_ready_in;

  always_comb begin
    ser_sel[PIN_TX] = ~cfg_q.gpl_sel[PIN_TX];
    ser_sel[PIN_RX] = ~cfg_q.gpl_sel[PIN_RX];
    ser_sel[PIN_RTS] = ~cfg_q.gpl_sel[PIN_RTS] & (cfg_q.flow_en | cfg_q.i2c_sel);
    ser_sel[PIN_CTS] = ~cfg_q.gpl_sel[PIN_CTS] & (cfg_q.flow_en | cfg_q.i2c_sel);
    fn_drive[PIN_TX] = tx_line_q;
    fn_oe[PIN_TX] = 1'b1;
    fn_drive[PIN_RX] = 1'b1; // receive pin is input only
    fn_oe[PIN_RX] = 1'b0;
    if (cfg_q.i2c_sel) begin
      fn_drive[PIN_RTS] = 1'b0; // open drain clock
      fn_oe[PIN_RTS] = i2c_scl_low_in;
      fn_drive[PIN_CTS] = 1'b0; // open drain data
      fn_oe[PIN_CTS] = i2c_sda_low_in;
    end else begin
      fn_drive[PIN_RTS] = rts_n;
      fn_oe[PIN_RTS] = 1'b1;
      fn_drive[PIN_CTS] = 1'b1; // clear-to-send is an input
      fn_oe[PIN_CTS] = 1'b0;
    end
  end

  // one pad cell per shared pin
  for (genvar i = 0; i < PIN_N; i++) begin : g_pad
    uhp_pad_cell #(
      .RESET_PULL((i < PIN_RTS) ? PULL_RESET_UART : PULL_RESET_HS)
    ) u_pad (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .serial_sel_in(ser_sel[i]),
      .fn_drive_in(fn_drive[i]),
      .fn_oe_in(fn_oe[i]),
      .gpl_in(gpl_in[i]),
      .pin_in(pin_in[i]),
      .pin_out(pin_out[i]),
      .pin_oe_out(pin_oe_out[i]),
      .pull_out(pull_out[i]),
      .sync_out(pin_sync[i])
    );
  end

  assign gpl_level_out = pin_sync;
  assign i2c_scl_out = pin_sync[PIN_RTS];
  assign i2c_sda_out = pin_sync[PIN_CTS];

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d; // clocks left in this bit
  logic [2:0] tx_bit_q, tx_bit_d; // data bit index
  logic [7:0] tx_sh_q, tx_sh_d; // data still to send
  logic tx_par_q, tx_par_d; // parity bit to send
  logic tx_stop2_q, tx_stop2_d; // second stop bit still due
  logic cts_ok; // host allows sending

  // clear-to-send is active low and only checked between characters
  assign cts_ok = ~flow_act | ~pin_sync[PIN_CTS];
  assign tx_ready_out = (tx_st_q == UHP_ST_IDLE) & cts_ok;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_par_d = tx_par_q;
    tx_stop2_d = tx_stop2_q;
    tx_line_d = tx_line_q;
    if (tx_st_q == UHP_ST_IDLE) begin
      tx_line_d = 1'b1; // idle high
      if (tx_valid_in && cts_ok) begin
        tx_sh_d = tx_data_in;
        tx_par_d = (^tx_data_in) ^ (cfg_q.parity == UHP_PAR_ODD);
        tx_stop2_d = cfg_q.two_stop;
        tx_cnt_d = div_eff - DIV_ONE;
        tx_line_d = 1'b0; // start bit
        tx_st_d = UHP_ST_START;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_d = tx_cnt_q - DIV_ONE;
    end else begin
      tx_cnt_d = div_eff - DIV_ONE;
      case (tx_st_q)
        UHP_ST_START: begin // lsb first
          tx_line_d = tx_sh_q[0];
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = '0;
          tx_st_d = UHP_ST_DATA;
        end
        UHP_ST_DATA: begin
          if (tx_bit_q == LAST_DATA_BIT) begin
            if (cfg_q.parity == UHP_PAR_NONE) begin
              tx_line_d = 1'b1;
              tx_st_d = UHP_ST_STOP;
            end else begin
              tx_line_d = tx_par_q;
              tx_st_d = UHP_ST_PARITY;
            end
          end else begin
            tx_line_d = tx_sh_q[0];
            tx_sh_d = {1'b0, tx_sh_q[7:1]};
            tx_bit_d = tx_bit_q + 3'h1;
          end
        end
        UHP_ST_PARITY: begin
          tx_line_d = 1'b1;
          tx_st_d = UHP_ST_STOP;
        end
        UHP_ST_STOP: begin
          if (tx_stop2_q) begin
            tx_stop2_d = 1'b0; // second stop bit
          end else begin
            tx_st_d = UHP_ST_IDLE;
          end
        end
        default: begin
          tx_st_d = UHP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_st_q <= UHP_ST_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_par_q <= tx_par_d;
      tx_stop2_q <= tx_stop2_d;
      tx_line_q <= tx_line_d;
    end
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic rx_line; // receive level, idle high when not serial
  logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d; // clocks to next sample
  logic [2:0] rx_bit_q, rx_bit_d; // data bit index
  logic [7:0] rx_sh_q, rx_sh_d; // assembled bits
  logic rx_perr_q, rx_perr_d; // parity error so far
  logic rx_ferr_q, rx_ferr_d; // framing error so far
  logic rx_stop2_q, rx_stop2_d; // second stop still due
  logic rx_valid_q, rx_valid_d; // character pulse
  logic [7:0] rx_data_q, rx_data_d; // last character
  logic rx_pe_q, rx_pe_d; // its parity flag
  logic rx_fe_q, rx_fe_d; // its framing flag

  assign rx_line = ser_sel[PIN_RX] ? pin_sync[PIN_RX] : 1'b1;

  // samples in mid-bit: half a bit after the falling edge, then every bit
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_perr_d = rx_perr_q;
    rx_ferr_d = rx_ferr_q;
    rx_stop2_d = rx_stop2_q;
    rx_valid_d = 1'b0;
    rx_data_d = rx_data_q;
    rx_pe_d = rx_pe_q;
    rx_fe_d = rx_fe_q;
    if (rx_st_q == UHP_ST_IDLE) begin
      if (!rx_line) begin // start edge
        rx_cnt_d = {1'b0, div_eff[DIV_W-1:1]};
        rx_perr_d = 1'b0;
        rx_ferr_d = 1'b0;
        rx_stop2_d = cfg_q.two_stop;
        rx_st_d = UHP_ST_START;
      end
    end else if (rx_cnt_q != '0) begin
      rx_cnt_d = rx_cnt_q - DIV_ONE;
    end else begin
      rx_cnt_d = div_eff - DIV_ONE;
      case (rx_st_q)
        UHP_ST_START: begin
          // a glitch shorter than half a bit is dropped
          rx_bit_d = '0;
          rx_st_d = rx_line ? UHP_ST_IDLE : UHP_ST_DATA;
        end
        UHP_ST_DATA: begin
          rx_sh_d = {rx_line, rx_sh_q[7:1]}; // lsb first
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == LAST_DATA_BIT) begin
            rx_st_d = (cfg_q.parity == UHP_PAR_NONE) ? UHP_ST_STOP : UHP_ST_PARITY;
          end
        end
        UHP_ST_PARITY: begin
          rx_perr_d = rx_line ^ (^rx_sh_q) ^ (cfg_q.parity == UHP_PAR_ODD);
          rx_st_d = UHP_ST_STOP;
        end
        UHP_ST_STOP: begin
          if (!rx_line) begin
            rx_ferr_d = 1'b1;
          end
          if (rx_stop2_q) begin
            rx_stop2_d = 1'b0; // first stop checked, second still due
          end else begin
            rx_valid_d = 1'b1;
            rx_data_d = rx_sh_q;
            rx_pe_d = rx_perr_q;
            rx_fe_d = rx_ferr_q | ~rx_line;
            rx_st_d = UHP_ST_IDLE;
          end
        end
        default: begin
          rx_st_d = UHP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_st_q <= UHP_ST_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_perr_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_stop2_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= '0;
      rx_pe_q <= 1'b0;
      rx_fe_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_perr_q <= rx_perr_d;
      rx_ferr_q <= rx_ferr_d;
      rx_stop2_q <= rx_stop2_d;
      rx_valid_q <= rx_valid_d;
      rx_data_q <= rx_data_d;
      rx_pe_q <= rx_pe_d;
      rx_fe_q <= rx_fe_d;
    end
  end

  assign rx_valid_out = rx_valid_q;
  assign rx_data_out = rx_data_q;
  assign rx_parity_err_out = rx_pe_q;
  assign rx_frame_err_out = rx_fe_q;

endmodule

// >>> uhp_host_port_assertions.sv
`timescale 1ns/10ps
module uhp_host_port_assertions
  import uhp_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic reset_in, // sync reset
  input wire uhp_cfg_t cfg_in, // configuration
  input wire uhp_gpl_t [PIN_N-1:0] gpl_in, // line control
  input wire logic tx_valid_in, // offered
  input wire logic tx_ready_out, // taken
  input wire logic rx_ready_in, // host may send
  input wire logic rx_valid_out, // received
  input wire logic rx_parity_err_out, // parity flag
  input wire logic rx_frame_err_out, // stop flag
  input wire logic i2c_scl_low_in, // pull clock low
  input wire logic [PIN_N-1:0] pin_in, // pad levels
  input wire logic [PIN_N-1:0] pin_out, // pad drive
  input wire logic [PIN_N-1:0] pin_oe_out, // pad enable
  input wire uhp_pull_t [PIN_N-1:0] pull_out // pad pulls
);
  // --------
  // checks
  // --------
  logic take; // character accepted
  logic cts_on; // cts gates transmit
  logic rts_on; // rts shows receive space
  assign take = tx_valid_in && tx_ready_out;
  assign cts_on = cfg_in.flow_en && !cfg_in.i2c_sel && !cfg_in.gpl_sel[PIN_CTS];
  assign rts_on = cfg_in.flow_en && !cfg_in.i2c_sel && !cfg_in.gpl_sel[PIN_RTS];
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  a_take_busy: assert property (take |=> (!tx_ready_out) [*2])
    else $error("ready stayed high after a take");
  // start bit stands at least eight clocks, divisor floor is far above
  a_start_low: assert property (take && !cfg_in.gpl_sel[PIN_TX] |=> ##1 (pin_oe_out[PIN_TX] && !pin_out[PIN_TX]) [*8])
    else $error("start bit not low");
  a_idle_high: assert property (tx_ready_out && $stable(cfg_in) && !cfg_in.gpl_sel[PIN_TX] |=> pin_out[PIN_TX])
    else $error("idle line not high");
  a_cts_gate: assert property ((cts_on && pin_in[PIN_CTS]) [*4] |-> !tx_ready_out)
    else $error("ready while cts high");
  a_rts_level: assert property (rts_on && $stable(cfg_in) |=> pin_oe_out[PIN_RTS] && pin_out[PIN_RTS] == !$past(rx_ready_in))
    else $error("rts not active low ready");
  a_i2c_drain: assert property (cfg_in.i2c_sel && !cfg_in.gpl_sel[PIN_RTS] && $stable(cfg_in)
    |=> pin_oe_out[PIN_RTS] == $past(i2c_scl_low_in) && !(pin_oe_out[PIN_RTS] && pin_out[PIN_RTS]))
    else $error("i2c clock not open drain");
  a_gpl_drive: assert property (cfg_in.gpl_sel[PIN_TX] && $stable(cfg_in)
    |=> pin_out[PIN_TX] == $past(gpl_in[PIN_TX].drive) && pin_oe_out[PIN_TX] == $past(gpl_in[PIN_TX].oe))
    else $error("tx pin not a general line");
  a_hs_general: assert property (!cfg_in.flow_en && !cfg_in.i2c_sel && $stable(cfg_in)
    |=> pin_oe_out[PIN_CTS] == $past(gpl_in[PIN_CTS].oe))
    else $error("cts pin not a general line");
  a_pull_sel: assert property (1'b1 |=> pull_out[PIN_RX] == $past(gpl_in[PIN_RX].pull))
    else $error("pull code not followed");
  a_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out)
    else $error("receive pulse too long");
  c_take: cover property (take);
  c_par_err: cover property (rx_valid_out && rx_parity_err_out);
  c_frame_err: cover property (rx_valid_out && rx_frame_err_out);
endmodule

bind uhp_host_port uhp_host_port_assertions u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg_in), .gpl_in(gpl_in), .tx_valid_in(tx_valid_in),
  .tx_ready_out(tx_ready_out), .rx_ready_in(rx_ready_in), .rx_valid_out(rx_valid_out),
  .rx_parity_err_out(rx_parity_err_out), .rx_frame_err_out(rx_frame_err_out), .i2c_scl_low_in(i2c_scl_low_in),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pull_out(pull_out)
);

// >>> uhp_host_model.sv
`timescale 1ns/10ps
module uhp_host_model
  import uhp_pkg::*;
(
  input wire logic clk_in, // times the bits
  input wire logic line_in, // device transmit wire
  input wire logic [DIV_W-1:0] div_in, // clocks per bit
  input wire uhp_par_t par_in, // agreed parity
  input wire logic two_stop_in, // agreed stops
  input wire logic hold_in, // 1: host not ready
  output logic host_tx_out, // host transmit wire
  output logic cts_n_out // active low clear-to-send
);
  // --------
  // host side
  // --------
  logic [7:0] got_data; // last character
  logic got_par; // its parity bit
  logic [1:0] got_stop; // its stop samples
  int got_len; // start bit clocks
  int got_n = 0; // characters seen
  assign cts_n_out = hold_in;
  initial host_tx_out = 1'b1; // idle high
  // start, lsb first, parity, stops, idle; errors only on request
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    logic [12:0] f;
    int n;
    f = {4'hF, b, 1'b0};
    n = 10 + int'(par_in != UHP_PAR_NONE) + int'(two_stop_in);
    if (par_in != UHP_PAR_NONE) begin
      f[9] = ((par_in == UHP_PAR_ODD) ? ~^b : ^b) ^ bad_par;
    end
    f[n-1] = ~bad_stop;
    for (int i = 0; i <= n; i++) begin
      host_tx_out = f[i];
      repeat (div_in) @(negedge clk_in);
    end
  endtask
  // receiver; start length is measured, so test bytes keep bit 0 high
  always begin : rx_side
    int len;
    @(negedge line_in);
    len = 0;
    do begin
      @(negedge clk_in);
      len++;
    end while (line_in === 1'b0 && len < 300000);
    got_len = len - 1;
    repeat (div_in / 2) @(negedge clk_in);
    got_data[0] = line_in;
    for (int i = 1; i < 8; i++) begin
      repeat (div_in) @(negedge clk_in);
      got_data[i] = line_in; // lsb first
    end
    if (par_in != UHP_PAR_NONE) begin
      repeat (div_in) @(negedge clk_in);
      got_par = line_in;
    end
    repeat (div_in) @(negedge clk_in);
    got_stop = {1'b1, line_in};
    if (two_stop_in) begin
      repeat (div_in) @(negedge clk_in);
      got_stop[1] = line_in;
    end
    got_n++;
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
`define CHK(name, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", name, e, s); end end
module tb_top
  import uhp_pkg::*;
;
  logic clk_in = 1'b0; // 250 MHz
  logic reset_in = 1'b1; // held at start
  uhp_cfg_t cfg_in; // configuration
  uhp_gpl_t [PIN_N-1:0] gpl_in; // line control
  logic tx_valid_in, rx_ready_in, i2c_scl_low_in, i2c_sda_low_in, tx_ready_out, rx_valid_out;
  logic rx_parity_err_out, rx_frame_err_out, i2c_scl_out, i2c_sda_out, host_tx, host_cts_n, host_hold;
  logic [7:0] tx_data_in, rx_data_out;
  logic [PIN_N-1:0] gpl_level_out, pin_in, pin_out, pin_oe_out;
  uhp_pull_t [PIN_N-1:0] pull_out;
  logic [DIV_W-1:0] host_div; // host bit time
  int miscompares = 0;
  int n_tests = 0;
  localparam logic [7:0] PAT [6] = '{8'hA5, 8'h3B, 8'hC7, 8'h01, 8'hFF, 8'h6D};
  always #2 clk_in = ~clk_in;
  // wire levels: a driver wins; released tx and rts rest high, rx and cts follow the host
  assign pin_in[PIN_TX] = pin_oe_out[PIN_TX] ? pin_out[PIN_TX] : 1'b1;
  assign pin_in[PIN_RX] = pin_oe_out[PIN_RX] ? pin_out[PIN_RX] : host_tx;
  assign pin_in[PIN_RTS] = pin_oe_out[PIN_RTS] ? pin_out[PIN_RTS] : 1'b1;
  assign pin_in[PIN_CTS] = pin_oe_out[PIN_CTS] ? pin_out[PIN_CTS] : host_cts_n;
  uhp_host_port dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg_in), .gpl_in(gpl_in),
    .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .rx_ready_in(rx_ready_in),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .rx_parity_err_out(rx_parity_err_out),
    .rx_frame_err_out(rx_frame_err_out), .i2c_scl_low_in(i2c_scl_low_in), .i2c_sda_low_in(i2c_sda_low_in),
    .i2c_scl_out(i2c_scl_out), .i2c_sda_out(i2c_sda_out), .gpl_level_out(gpl_level_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pull_out(pull_out));
  uhp_host_model host (.clk_in(clk_in), .line_in(pin_in[PIN_TX]), .div_in(host_div), .par_in(cfg_in.parity),
    .two_stop_in(cfg_in.two_stop), .hold_in(host_hold), .host_tx_out(host_tx), .cts_n_out(host_cts_n));
  // --------
  // tasks
  // --------
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic too_long();
    miscompares++;
    $display("[ERR] wait bound ran out");
    close_out();
  endtask
  // config only while both directions idle, then let it settle
  task automatic set_cfg(input logic [DIV_W-1:0] d, input int p, input logic two, input logic fl,
                         input logic i2c, input logic [3:0] sel);
    cfg_in = '{divisor: d, parity: uhp_par_t'(p[1:0]), two_stop: two, flow_en: fl, i2c_sel: i2c, gpl_sel: sel};
    repeat (4) @(negedge clk_in);
  endtask
  // offer at a falling edge, hold until ready is seen high
  task automatic tx_send(input logic [7:0] b);
    int i;
    tx_data_in = b;
    tx_valid_in = 1'b1;
    for (i = 0; i < 500 && tx_ready_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 500) too_long();
    @(negedge clk_in);
    tx_valid_in = 1'b0;
  endtask
  task automatic wait_host(input int prev);
    int i;
    for (i = 0; i < 5000 && host.got_n == prev; i++) @(negedge clk_in);
    if (i == 5000) too_long();
  endtask
  task automatic rx_one(input logic [7:0] b, input logic bp, input logic bs);
    int i;
    fork
      host.send(b, bp, bs);
      for (i = 0; i < 5000 && rx_valid_out !== 1'b1; i++) @(negedge clk_in);
    join
    if (i == 5000) too_long();
  endtask
  // --------
  // sequence
  // --------
  initial begin : main
    int prev;
    cfg_in = '{divisor: 18'h00050, parity: UHP_PAR_NONE, two_stop: 1'b0, flow_en: 1'b0, i2c_sel: 1'b0, gpl_sel: 4'h0};
    for (int i = 0; i < PIN_N; i++) gpl_in[i] = '{drive: 1'b1, oe: 1'b0, pull: UHP_PULL_WEAK_DOWN};
    {tx_valid_in, i2c_scl_low_in, i2c_sda_low_in, host_hold, tx_data_in} = '0;
    rx_ready_in = 1'b1;
    host_div = 18'h00050;
    repeat (19) @(negedge clk_in);
    `CHK("enables in reset", 4'h0, pin_oe_out)
    `CHK("tx pull in reset", UHP_PULL_STRONG_UP, pull_out[PIN_TX])
    `CHK("cts pull in reset", UHP_PULL_WEAK_UP, pull_out[PIN_CTS])
    @(negedge clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    `CHK("pull after reset", UHP_PULL_WEAK_DOWN, pull_out[PIN_TX])
    // every parity and stop choice; the last asks below the floor
    for (int k = 0; k < 6; k++) begin
      host_div = (k == 5) ? DIV_MIN : 18'h00050;
      set_cfg((k == 5) ? 18'h0000A : 18'h00050, k % 3, 1'(k / 3), 1'b0, 1'b0, 4'h0);
      prev = host.got_n;
      tx_send(PAT[k]);
      wait_host(prev);
      `CHK("tx data", PAT[k], host.got_data)
      `CHK("bit length", 32'(host_div), host.got_len)
      `CHK("stop bits", 2'b11, host.got_stop)
      if (k % 3 != 0) `CHK("parity bit", (k % 3 == 1) ? ~^PAT[k] : ^PAT[k], host.got_par)
      rx_one(~PAT[k], 1'b0, 1'b0);
      `CHK("rx data", ~PAT[k], rx_data_out)
      `CHK("rx flags", 2'b00, {rx_parity_err_out, rx_frame_err_out})
    end
    rx_one(8'h5A, 1'b1, 1'b0);
    `CHK("parity error", 1'b1, rx_parity_err_out)
    rx_one(8'h5A, 1'b0, 1'b1);
    `CHK("second stop low", 2'b01, {rx_parity_err_out, rx_frame_err_out})
    // flow control: host holds cts high, then lets go
    host_div = 18'h00050;
    host_hold = 1'b1;
    set_cfg(18'h00050, 0, 1'b0, 1'b1, 1'b0, 4'h0);
    rx_ready_in = 1'b0;
    repeat (3) @(negedge clk_in);
    `CHK("rts when full", 1'b1, pin_out[PIN_RTS])
    rx_ready_in = 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK("rts when ready", 1'b0, pin_out[PIN_RTS])
    tx_data_in = 8'h81;
    tx_valid_in = 1'b1;
    repeat (40) @(negedge clk_in);
    `CHK("ready under cts high", 1'b0, tx_ready_out)
    host_hold = 1'b0;
    prev = host.got_n;
    tx_send(8'h81);
    wait_host(prev);
    `CHK("flow tx data", 8'h81, host.got_data)
    for (int i = 0; i < 500 && tx_ready_out !== 1'b1; i++) @(negedge clk_in);
    if (tx_ready_out !== 1'b1) too_long();
    // i2c takes the handshake pins even with flow requested
    host_hold = 1'b1;
    set_cfg(18'h00050, 0, 1'b0, 1'b1, 1'b1, 4'h0);
    i2c_scl_low_in = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK("scl pulled", 2'b10, {pin_oe_out[PIN_RTS], pin_out[PIN_RTS]})
    `CHK("i2c levels", 3'b011, {i2c_scl_out, i2c_sda_out, tx_ready_out})
    i2c_scl_low_in = 1'b0;
    i2c_sda_low_in = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK("i2c levels swapped", 2'b10, {i2c_scl_out, i2c_sda_out})
    i2c_sda_low_in = 1'b0;
    // all four pins as general lines, then handshake pins only
    for (int i = 0; i < PIN_N; i++) gpl_in[i] = '{drive: (i % 2 == 0), oe: 1'b1, pull: UHP_PULL_STRONG_DOWN};
    set_cfg(18'h00050, 0, 1'b0, 1'b0, 1'b0, 4'hF);
    `CHK("general drive", 12'h5F5, {pin_out, pin_oe_out, gpl_level_out})
    `CHK("general pull", UHP_PULL_STRONG_DOWN, pull_out[PIN_RTS])
    set_cfg(18'h00050, 0, 1'b0, 1'b0, 1'b0, 4'h0);
    `CHK("handshake as lines", 4'hD, {pin_oe_out[3:2], pin_out[3:2]})
    `CHK("serial pins back", 3'b011, {pin_oe_out[PIN_RX], pin_oe_out[PIN_TX], pin_out[PIN_TX]})
    close_out();
  end
endmodule
